// ---- bench/dtpb_pin_model.sv ----
`timescale 1ns/1ps
module dtpb_pin_model (
  input  wire logic clk_sys,
  input  wire logic pin,
  input  wire logic pin_oe,
  output logic      ext_clk,
  output logic      rc_clk,
  output logic      pad
);
  // ****************************************
  // Pad and clock sources.
  // ****************************************
  // The pad has a pull-up, so a released pin reads high, not its last level.
  assign pad = pin_oe ? pin : 1'b1;

  initial begin
    ext_clk = 1'b0;
    rc_clk  = 1'b0;
  end

  // Edges are four cycles apart so that a synchronising input never misses one.
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      ext_clk <= ~ext_clk;
    end
    repeat (6) @(posedge clk_sys);
  endtask : toggle

  task automatic rc_pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      rc_clk <= ~rc_clk;
      repeat (4) @(posedge clk_sys);
      rc_clk <= ~rc_clk;
    end
    repeat (6) @(posedge clk_sys);
  endtask : rc_pulse
endmodule : dtpb_pin_model

// ---- bench/dtpb_sva.sv ----
`timescale 1ns/1ps
module dtpb_sva_checker
  import dtpb_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       comparator_output_enable,
  input wire logic       comparator_output,
  input wire logic       shared_output_pin,
  input wire logic       shared_output_pin_oe,
  input wire logic       timer_irq
);
  logic pwm_on, run_on, tone_on, irq_on, glob_on;

  // ****************************************
  // Shadow copies of the enable bits.
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {pwm_on, run_on, tone_on, irq_on, glob_on} <= 5'h00;
    end else if (reg_write) begin
      case (reg_addr)
        DTPB_ADDR_CONTROL_FIRST: {pwm_on, run_on} <= {reg_wdata[7], reg_wdata[0]};
        DTPB_ADDR_TONE_CONTROL:  tone_on <= reg_wdata[7];
        DTPB_ADDR_IRQ_ENABLE:    irq_on <= reg_wdata[3];
        DTPB_ADDR_PROC_CONTROL:  glob_on <= reg_wdata[7];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Properties.
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence low_write_stopped;
    reg_write && reg_addr == DTPB_ADDR_RELOAD_LOW && !run_on;
  endsequence
  sequence quiet_then_read;
    !reg_write ##1 !reg_write && reg_read && reg_addr == DTPB_ADDR_RELOAD_LOW;
  endsequence
  // Four cycles cover the pin pipeline, whatever its exact depth.
  sequence cmp_held;
    (comparator_output_enable && $stable(comparator_output))[*4];
  endsequence

  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (reg_read && reg_addr > DTPB_ADDR_PROC_CONTROL
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  stopped_load_a: assert property (low_write_stopped ##1 quiet_then_read
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("stopped load not seen");
  cmp_priority_a: assert property (cmp_held
    |-> shared_output_pin == comparator_output && shared_output_pin_oe)
    else $error("comparator not on pin");
  pin_release_a: assert property ((!comparator_output_enable && !pwm_on && !tone_on)[*4]
    |-> !shared_output_pin_oe) else $error("pin driven while no source on");
  pin_drive_a: assert property ((pwm_on || tone_on)[*4] |-> shared_output_pin_oe)
    else $error("pin not driven");
  global_gate_a: assert property ((!glob_on)[*3] |-> !timer_irq)
    else $error("request without global enable");
  enable_gate_a: assert property ((!irq_on)[*3] |-> !timer_irq)
    else $error("request without timer enable");
endmodule : dtpb_sva_checker

bind dtpb_down_timer dtpb_sva_checker sva_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .comparator_output_enable, .comparator_output,
  .shared_output_pin, .shared_output_pin_oe, .timer_irq);

// ---- bench/tb_down_timer_pwm_buzzer.sv ----
`timescale 1ns/1ps
module tb_down_timer_pwm_buzzer
  import dtpb_pkg::*;
;
  localparam logic [3:0] C1 = DTPB_ADDR_CONTROL_FIRST;
  localparam logic [3:0] C2 = DTPB_ADDR_CONTROL_SECOND;
  localparam logic [3:0] RLO = DTPB_ADDR_RELOAD_LOW;
  localparam logic [3:0] SHI = DTPB_ADDR_SHARED_HIGH;
  logic        clk_sys, reset_n, reg_write, reg_read, cmp_en, cmp_out;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, m;
  logic        pin, pin_oe, timer_irq, ext_clk, rc_clk, pad;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$], mask_q[$];
  logic [31:0] seed = 32'd34;
  logic [15:0] hi, tg;
  logic [9:0]  duty [4] = '{10'h000, 10'h100, 10'h3FF, 10'h100};
  logic [15:0] high_exp [4] = '{16'd0, 16'd1024, 16'd4092, 16'd1024};
  int          fails, num_checks;

  dtpb_down_timer dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .external_count_clock(ext_clk), .internal_fast_rc_clock(rc_clk),
    .comparator_output_enable(cmp_en), .comparator_output(cmp_out),
    .shared_output_pin(pin), .shared_output_pin_oe(pin_oe), .timer_irq);
  dtpb_pin_model pin_u (.clk_sys, .pin, .pin_oe, .ext_clk, .rc_clk, .pad);

  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // A spare edge after each strobe keeps a strobe from being set twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] mk);
    exp_q.push_back(e);
    mask_q.push_back(mk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task automatic rd_count(input logic [9:0] v);
    rd(RLO, v[7:0], 8'hFF);
    rd(SHI, {2'b00, v[9:8], 4'h0}, 8'h30);
  endtask : rd_count

  task automatic look();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  task automatic measure(input int n);
    logic last;
    hi = 16'h0000;
    tg = 16'h0000;
    last = pin;
    repeat (n) begin
      @(negedge clk_sys);
      hi += {15'h0000, pin};
      tg += {15'h0000, pin !== last};
      last = pin;
    end
    @(posedge clk_sys);
  endtask : measure

  always @(posedge clk_sys) rd_seen <= reg_read;
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1) begin
      m = mask_q.pop_front();
      check("read data", exp_q.pop_front() & m, reg_rdata & m);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    reset_n = 1'b0;
    {reg_write, reg_read, cmp_en, cmp_out} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wr(4'hC, 8'hFF);
    // The prescaler has counted the instruction clock from the first edge after reset.
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], (a == 5) ? 8'h0D : 8'h00, 8'hFF);
    end
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      wr(SHI, {2'b00, seed[9:8], 4'h0});
      wr(RLO, seed[7:0]);
      rd_count(seed[9:0]);
    end
    wr(C2, 8'h28);
    wr(SHI, 8'h20);
    wr(RLO, 8'h34);
    rd_count(10'h234);
    pin_u.toggle(2);
    rd_count(10'h234);
    wr(C1, 8'h03);
    pin_u.toggle(3);
    rd_count(10'h232);
    wr(C2, 8'h38);
    pin_u.toggle(3);
    rd_count(10'h230);
    for (int c = 0; c < 8; c++) begin
      wr(C2, {5'b00100, c[2:0]});
      pin_u.toggle(4 << c);
      rd_count(10'h22F - c[9:0]);
    end
    wr(C2, 8'h28);
    wr(C1, 8'h0B);
    pin_u.toggle(2);
    pin_u.rc_pulse(3);
    rd_count(10'h225);
    wr(C1, 8'h00);
    wr(SHI, 8'h00);
    wr(RLO, 8'h02);
    wr(C1, 8'h05);
    wr(DTPB_ADDR_IRQ_ENABLE, 8'h08);
    pin_u.toggle(8);
    rd_count(10'h000);
    rd(DTPB_ADDR_IRQ_FLAG, 8'h08, 8'h08);
    look();
    check("request", 16'h0000, {15'h0000, timer_irq});
    @(posedge clk_sys);
    wr(DTPB_ADDR_PROC_CONTROL, 8'h80);
    look();
    check("request", 16'h0001, {15'h0000, timer_irq});
    @(posedge clk_sys);
    wr(DTPB_ADDR_IRQ_FLAG, 8'h00);
    look();
    check("request", 16'h0000, {15'h0000, timer_irq});
    @(posedge clk_sys);
    wr(C1, 8'h01);
    pin_u.toggle(2);
    rd_count(10'h3FF);
    wr(SHI, 8'h10);
    wr(RLO, 8'h05);
    rd_count(10'h3FF);
    wr(C1, 8'h03);
    pin_u.toggle(2050);
    rd_count(10'h104);
    wr(C1, 8'h00);
    wr(C2, 8'h08);
    wr(SHI, 8'h30);
    wr(RLO, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      wr(C1, {1'b1, i[0], 6'h00});
      look();
      check("pin", {14'h0000, 1'b1, i[0]}, {14'h0000, pin_oe, pin});
      @(posedge clk_sys);
    end
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(DTPB_ADDR_TONE_CONTROL, 8'h80);
      wr(SHI, {6'b001100, duty[i][9:8]});
      wr(DTPB_ADDR_DUTY_LOW, duty[i][7:0]);
      wr(C1, 8'h83);
      repeat (1100) @(posedge clk_sys);
      measure(4096);
      check("active cycles", high_exp[i], hi);
    end
    wr(C1, 8'h01);
    wr(C2, 8'h00);
    for (int c = 0; c < 4; c++) begin
      if (c == 3) begin
        wr(SHI, 8'h00);
        wr(C1, 8'h00);
        wr(RLO, 8'h03);
        wr(C2, 8'h08);
        wr(C1, 8'h03);
      end
      wr(DTPB_ADDR_TONE_CONTROL, (c == 3) ? 8'h88 : {5'b10000, c[2:0]});
      repeat (64) @(posedge clk_sys);
      measure(1024);
      check("tone edges", (c == 3) ? 16'd128 : 16'd256 >> c, tg);
    end
    cmp_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      cmp_out <= seed[0];
      look();
      check("pin", {14'h0000, 1'b1, seed[0]}, {14'h0000, pin_oe, pin});
      @(posedge clk_sys);
    end
    cmp_en <= 1'b0;
    wr(DTPB_ADDR_TONE_CONTROL, 8'h00);
    look();
    check("pad", 16'h0001, {15'h0000, pad});
    @(posedge clk_sys);
    seed = xs(seed);
    cmp_en <= seed[0];
    look();
    check("pad", {15'h0000, !seed[0] || cmp_out}, {15'h0000, pad});
    stop_test();
  end
endmodule : tb_down_timer_pwm_buzzer

// ---- verilog/dtpb_down_timer.sv ----
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Ten-bit down counter; reads return live count.
// - High reload bits first; running loads at underflow.
// - Stopped timer loads buffer on low write.
// - Control bit 0 enables counting.
// - Source: fast RC, external pin, or instruction.
// - Edge select: 1 falling, 0 rising.
// - Active-low enable inserts prescaler, three-bit ratio.
// - Prescaler count is readable.
// - One-shot counts once then stops.
// - Free run reloads buffer or 0x3FF.
// - Underflow sets sticky flag, gated interrupt request.
// - Control bit 7 drives PWM on pin.
// - Control bit 6 selects PWM active low.
// - Duty zero never active; compare count.
// - New duty takes effect after underflow.
// - Tone enable drives tone on pin.
// - Tone source: prescaler or timer output.
// - Tone divides source 1:2 to 1:256.
// - PWM wins over tone on pin.
// - Comparator output wins over everything.
// - Global enable bit 7 gates interrupt.
module dtpb_down_timer
  import dtpb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       external_count_clock,
  input  wire logic       internal_fast_rc_clock,
  input  wire logic       comparator_output_enable,
  input  wire logic       comparator_output,
  output logic            shared_output_pin,
  output logic            shared_output_pin_oe,
  output logic            timer_irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] timer_control_first;
  logic [7:0] timer_control_second;
  logic [1:0] reload_hi;
  logic [1:0] duty_hi;
  logic [9:0] reload_buffer;
  logic [9:0] duty_pending;
  logic [9:0] duty_active;
  logic [9:0] count;
  logic       one_shot_done;
  logic [7:0] tone_control_register;
  logic       underflow_flag;
  logic       underflow_irq_enable;
  logic       global_irq_enable;
  logic       ext_prev;
  logic       rc_prev;
  logic       pulse_width_output;

  logic       wr_control_first;
  logic       wr_control_second;
  logic       wr_reload_low;
  logic       wr_shared_high;
  logic       wr_duty_low;
  logic       wr_tone;
  logic       wr_flag;
  logic       wr_enable;
  logic       wr_proc;
  logic       running;
  logic       underflow;
  logic       ext_edge;
  logic       rc_edge;
  logic       next_pin;
  logic       next_oe;
  logic [9:0] next_count;
  logic [7:0] next_rdata;

  dtpb_tick_if link ();

  dtpb_scaler u_scaler (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .link    (link)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  assign wr_control_first  = reg_write && (reg_addr == DTPB_ADDR_CONTROL_FIRST);
  assign wr_control_second = reg_write && (reg_addr == DTPB_ADDR_CONTROL_SECOND);
  assign wr_reload_low     = reg_write && (reg_addr == DTPB_ADDR_RELOAD_LOW);
  assign wr_shared_high    = reg_write && (reg_addr == DTPB_ADDR_SHARED_HIGH);
  assign wr_duty_low       = reg_write && (reg_addr == DTPB_ADDR_DUTY_LOW);
  assign wr_tone           = reg_write && (reg_addr == DTPB_ADDR_TONE_CONTROL);
  assign wr_flag           = reg_write && (reg_addr == DTPB_ADDR_IRQ_FLAG);
  assign wr_enable         = reg_write && (reg_addr == DTPB_ADDR_IRQ_ENABLE);
  assign wr_proc           = reg_write && (reg_addr == DTPB_ADDR_PROC_CONTROL);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_control_first   <= DTPB_RESET_BYTE;
      timer_control_second  <= DTPB_RESET_BYTE;
      tone_control_register <= DTPB_RESET_BYTE;
      underflow_irq_enable  <= 1'b0;
      global_irq_enable     <= 1'b0;
    end else begin
      if (wr_control_first) begin
        timer_control_first <= reg_wdata;
      end
      if (wr_control_second) begin
        timer_control_second <= reg_wdata;
      end
      if (wr_tone) begin
        tone_control_register <= reg_wdata;
      end
      if (wr_enable) begin
        underflow_irq_enable <= reg_wdata[DTPB_BIT_UNDERFLOW];
      end
      if (wr_proc) begin
        global_irq_enable <= reg_wdata[DTPB_BIT_GLOBAL_IRQ];
      end
    end
  end

  // ****************************************************************
  // Count source
  // ****************************************************************
  // Pins are synchronous, so one stage of history is enough for edges.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev <= 1'b0;
      rc_prev  <= 1'b0;
    end else begin
      ext_prev <= external_count_clock;
      rc_prev  <= internal_fast_rc_clock;
    end
  end

  assign ext_edge = timer_control_second[DTPB_BIT_EDGE_SELECT] ?
                    (ext_prev && !external_count_clock) :
                    (!ext_prev && external_count_clock);
  assign rc_edge  = !rc_prev && internal_fast_rc_clock;

  // The instruction clock is this block's own clock, so it ticks every cycle.
  assign link.source_tick = timer_control_first[DTPB_BIT_FAST_RC] ? rc_edge :
                            timer_control_second[DTPB_BIT_SOURCE_SELECT] ? ext_edge :
                            1'b1;
  assign link.prescaler_enable_n     = timer_control_second[DTPB_BIT_PRESCALER_EN_N];
  assign link.prescaler_ratio_select = timer_control_second[2:0];
  assign link.tone_frequency_select  = tone_control_register[3:0];
  assign link.underflow              = underflow;

  // ****************************************************************
  // Down counter
  // ****************************************************************
  assign running   = timer_control_first[DTPB_BIT_RUN_ENABLE] && !one_shot_done;
  assign underflow = running && link.timer_tick && (count == DTPB_RESET_WORD);

  always_comb begin
    next_count = count;
    if (underflow) begin
      if (timer_control_first[DTPB_BIT_ONE_SHOT]) begin
        next_count = DTPB_RESET_WORD;
      end else if (timer_control_first[DTPB_BIT_RELOAD_SELECT]) begin
        next_count = reload_buffer;
      end else begin
        next_count = DTPB_FREE_RUN_LOAD;
      end
    end else if (running && link.timer_tick) begin
      next_count = count - 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= DTPB_RESET_WORD;
    end else if (wr_reload_low && !timer_control_first[DTPB_BIT_RUN_ENABLE]) begin
      count <= {reload_hi, reg_wdata};
    end else begin
      count <= next_count;
    end
  end

  // A one-shot run parks at zero until software rewrites the first control register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      one_shot_done <= 1'b0;
    end else if (wr_control_first) begin
      one_shot_done <= 1'b0;
    end else if (underflow && timer_control_first[DTPB_BIT_ONE_SHOT]) begin
      one_shot_done <= 1'b1;
    end
  end

  // ****************************************************************
  // Reload and duty buffers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reload_hi     <= DTPB_RESET_HI;
      duty_hi       <= DTPB_RESET_HI;
      reload_buffer <= DTPB_RESET_WORD;
      duty_pending  <= DTPB_RESET_WORD;
    end else begin
      if (wr_shared_high) begin
        reload_hi <= reg_wdata[DTPB_BIT_RELOAD_HI_LSB +: 2];
        duty_hi   <= reg_wdata[DTPB_BIT_DUTY_HI_LSB +: 2];
      end
      if (wr_reload_low) begin
        reload_buffer <= {reload_hi, reg_wdata};
      end
      if (wr_duty_low) begin
        duty_pending <= {duty_hi, reg_wdata};
      end
    end
  end

  // The duty in use changes only at a frame boundary, so no frame is torn.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      duty_active <= DTPB_RESET_WORD;
    end else if (underflow) begin
      duty_active <= duty_pending;
    end
  end

  // ****************************************************************
  // Interrupt flag
  // ****************************************************************
  // A write of 0 clears the flag, but an underflow in the same cycle wins.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      underflow_flag <= 1'b0;
    end else if (underflow) begin
      underflow_flag <= 1'b1;
    end else if (wr_flag && !reg_wdata[DTPB_BIT_UNDERFLOW]) begin
      underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= underflow_flag && underflow_irq_enable && global_irq_enable;
    end
  end

  // ****************************************************************
  // PWM and shared pin
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_width_output <= 1'b0;
    end else begin
      pulse_width_output <= (count < duty_active) ^
                            timer_control_first[DTPB_BIT_PWM_ACTIVE_LOW];
    end
  end

  always_comb begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    if (comparator_output_enable) begin
      next_pin = comparator_output;
      next_oe  = 1'b1;
    end else if (timer_control_first[DTPB_BIT_PWM_OUT_ENABLE]) begin
      next_pin = pulse_width_output;
      next_oe  = 1'b1;
    end else if (tone_control_register[DTPB_BIT_TONE_ENABLE]) begin
      next_pin = link.tone_output;
      next_oe  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shared_output_pin    <= 1'b0;
      shared_output_pin_oe <= 1'b0;
    end else begin
      shared_output_pin    <= next_pin;
      shared_output_pin_oe <= next_oe;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    next_rdata = DTPB_RESET_BYTE;
    unique case (reg_addr)
      DTPB_ADDR_CONTROL_FIRST:  next_rdata = timer_control_first;
      DTPB_ADDR_CONTROL_SECOND: next_rdata = timer_control_second;
      DTPB_ADDR_RELOAD_LOW:     next_rdata = count[7:0];
      DTPB_ADDR_SHARED_HIGH:    next_rdata = {2'h0, count[9:8], 2'h0, duty_hi};
      DTPB_ADDR_DUTY_LOW:       next_rdata = duty_pending[7:0];
      DTPB_ADDR_PRESCALE_COUNT: next_rdata = link.prescaler_count_value;
      DTPB_ADDR_TONE_CONTROL:   next_rdata = tone_control_register;
      DTPB_ADDR_IRQ_FLAG:       next_rdata = {4'h0, underflow_flag, 3'h0};
      DTPB_ADDR_IRQ_ENABLE:     next_rdata = {4'h0, underflow_irq_enable, 3'h0};
      DTPB_ADDR_PROC_CONTROL:   next_rdata = {global_irq_enable, 7'h00};
      default:                  next_rdata = DTPB_RESET_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= DTPB_RESET_BYTE;
    end else begin
      reg_rdata <= reg_read ? next_rdata : DTPB_RESET_BYTE;
    end
  end

endmodule : dtpb_down_timer

// ---- verilog/dtpb_pkg.sv ----
package dtpb_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] DTPB_ADDR_CONTROL_FIRST  = 4'h0;
  localparam logic [3:0] DTPB_ADDR_CONTROL_SECOND = 4'h1;
  localparam logic [3:0] DTPB_ADDR_RELOAD_LOW     = 4'h2;
  localparam logic [3:0] DTPB_ADDR_SHARED_HIGH    = 4'h3;
  localparam logic [3:0] DTPB_ADDR_DUTY_LOW       = 4'h4;
  localparam logic [3:0] DTPB_ADDR_PRESCALE_COUNT = 4'h5;
  localparam logic [3:0] DTPB_ADDR_TONE_CONTROL   = 4'h6;
  localparam logic [3:0] DTPB_ADDR_IRQ_FLAG       = 4'h7;
  localparam logic [3:0] DTPB_ADDR_IRQ_ENABLE     = 4'h8;
  localparam logic [3:0] DTPB_ADDR_PROC_CONTROL   = 4'h9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DTPB_BIT_RUN_ENABLE     = 0;
  localparam int DTPB_BIT_RELOAD_SELECT  = 1;
  localparam int DTPB_BIT_ONE_SHOT       = 2;
  localparam int DTPB_BIT_FAST_RC        = 3;
  localparam int DTPB_BIT_PWM_ACTIVE_LOW = 6;
  localparam int DTPB_BIT_PWM_OUT_ENABLE = 7;
  localparam int DTPB_BIT_PRESCALER_EN_N = 3;
  localparam int DTPB_BIT_EDGE_SELECT    = 4;
  localparam int DTPB_BIT_SOURCE_SELECT  = 5;
  localparam int DTPB_BIT_RELOAD_HI_LSB  = 4;
  localparam int DTPB_BIT_DUTY_HI_LSB    = 0;
  localparam int DTPB_BIT_TONE_ENABLE    = 7;
  localparam int DTPB_BIT_TONE_SOURCE    = 3;
  localparam int DTPB_BIT_UNDERFLOW      = 3;
  localparam int DTPB_BIT_GLOBAL_IRQ     = 7;

  // ****************************************************************
  // Reset values and fixed counts
  // ****************************************************************
  localparam logic [7:0] DTPB_RESET_BYTE    = 8'h00;
  localparam logic [9:0] DTPB_RESET_WORD    = 10'h000;
  localparam logic [9:0] DTPB_FREE_RUN_LOAD = 10'h3FF;
  localparam logic [1:0] DTPB_RESET_HI      = 2'h0;

  // Mask of the low (code + 1) bits: the divider wraps when they are all ones.
  function automatic logic [7:0] dtpb_ratio_mask(input logic [2:0] code);
    dtpb_ratio_mask = 8'hFF >> (3'h7 - code);
  endfunction : dtpb_ratio_mask

endpackage : dtpb_pkg

// ---- verilog/dtpb_scaler.sv ----
`timescale 1ns/1ps
module dtpb_scaler
  import dtpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  dtpb_tick_if.scaler link
);

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [7:0] count;
  logic [7:0] tone_count;
  logic       tone_level;
  logic       scaled_tick;
  logic       tone_event;
  logic [7:0] tone_mask;

  assign scaled_tick = link.source_tick &&
                       ((count & dtpb_ratio_mask(link.prescaler_ratio_select)) ==
                        dtpb_ratio_mask(link.prescaler_ratio_select));
  // A cleared active-low enable puts the divider in the count path.
  assign link.timer_tick = link.prescaler_enable_n ? link.source_tick : scaled_tick;
  assign link.prescaler_count_value = count;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= DTPB_RESET_BYTE;
    end else if (link.source_tick) begin
      count <= count + 8'h01;
    end
  end

  // ****************************************************************
  // Tone divider
  // ****************************************************************
  assign tone_event = link.tone_frequency_select[DTPB_BIT_TONE_SOURCE] ?
                      link.underflow : scaled_tick;
  assign tone_mask  = dtpb_ratio_mask(link.tone_frequency_select[2:0]);
  assign link.tone_output = tone_level;

  // The level flips each time the divider wraps, giving a square wave.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tone_count <= DTPB_RESET_BYTE;
      tone_level <= 1'b0;
    end else if (tone_event) begin
      tone_count <= tone_count + 8'h01;
      if ((tone_count & tone_mask) == tone_mask) begin
        tone_level <= ~tone_level;
      end
    end
  end

endmodule : dtpb_scaler

// ---- verilog/dtpb_tick_if.sv ----
`timescale 1ns/1ps
interface dtpb_tick_if;
  logic       source_tick;
  logic       prescaler_enable_n;
  logic [2:0] prescaler_ratio_select;
  logic [3:0] tone_frequency_select;
  logic       underflow;
  logic       timer_tick;
  logic [7:0] prescaler_count_value;
  logic       tone_output;

  modport timer (
    output source_tick,
    output prescaler_enable_n,
    output prescaler_ratio_select,
    output tone_frequency_select,
    output underflow,
    input  timer_tick,
    input  prescaler_count_value,
    input  tone_output
  );

  modport scaler (
    input  source_tick,
    input  prescaler_enable_n,
    input  prescaler_ratio_select,
    input  tone_frequency_select,
    input  underflow,
    output timer_tick,
    output prescaler_count_value,
    output tone_output
  );
endinterface : dtpb_tick_if
